// [dv/adc_conversion_control_tb.sv]
// Self-checking bench for the converter control through its register bus.
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adc_conversion_control_tb;
  // ****************************************
  // Signals, design and analog model
  // ****************************************
  localparam int CONV = `ADCC_CONV_NUM;
  logic clk_i, sys_rst_i, ce_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdq;
  logic pready_o, pslverr_o, errq, global_irq_enable_i;
  logic [7:0] port_direction_reg_i, port_option_reg_i, port_data_reg_i;
  logic comparator_i, at_upper_reference_i, at_lower_reference_i;
  logic [7:0] analog_select_o, dac_code_o;
  logic sample_hold_o, converter_powerdown_o, irq_o;
  logic [8:0] level;
  int fail_count, tests_run;

  adcc_ctrl u_dut (.clk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .port_direction_reg_i, .port_option_reg_i,
    .port_data_reg_i, .global_irq_enable_i, .comparator_i, .at_upper_reference_i,
    .at_lower_reference_i, .analog_select_o, .dac_code_o, .sample_hold_o,
    .converter_powerdown_o, .irq_o);
  adcc_analog_model u_analog (.level_i(level), .dac_code_i(dac_code_o),
    .analog_select_i(analog_select_o), .powerdown_i(converter_powerdown_o),
    .comparator_o(comparator_i), .at_upper_o(at_upper_reference_i),
    .at_lower_o(at_lower_reference_i));

  // ****************************************
  // Bus and checking tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdq = prdata_o;
    errq = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdq, exp);
  endtask : rd
  // Counts falling edges from a start write until the interrupt line rises.
  task automatic irq_wait(input logic [31:0] exp);
    int n;
    logic prv;
    n = 0;
    prv = 1'b1;
    do begin
      @(negedge clk_i);
      n++;
      if (irq_o === 1'b1 && prv === 1'b0) break;
      prv = irq_o;
    end while (n < 80);
    check(n, exp);
  endtask : irq_wait
  task automatic conv(input logic [8:0] v, input logic [7:0] res);
    level <= v;
    xfer(1'b1, `ADCC_ADDR_CTRL, 32'h3);
    irq_wait(CONV + 2);
    rd(`ADCC_ADDR_RESULT, {24'h0, res});
    check(dac_code_o, {24'h0, res});
  endtask : conv
  task automatic results;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ****************************************
  // Clock, watchdog and test sequence
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #200us;
    fail_count++;
    results();
  end
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {fail_count, tests_run, level} = '0;
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    global_irq_enable_i = 1'b1;
    port_direction_reg_i = 8'hfb;
    port_option_reg_i = 8'h04;
    port_data_reg_i = 8'h00;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`ADCC_ADDR_CTRL, 32'h4);
    check(converter_powerdown_o, 1'b1);
    rd(`ADCC_ADDR_IEN, 32'h0);
    rd(12'h020, 32'h0);
    check(errq, 1'b1);
    xfer(1'b1, `ADCC_ADDR_CTRL, 32'h2);
    rd(`ADCC_ADDR_CTRL, 32'h2);
    check(converter_powerdown_o, 1'b0);
    check(analog_select_o, 8'h04);
    conv(9'h000, 8'h00);
    conv(9'h05a, 8'h5a);
    conv(9'h0ff, 8'hff);
    conv(9'h100, 8'hff);
    conv(9'h1c0, 8'hff);
    xfer(1'b1, `ADCC_ADDR_CTRL, 32'h3);
    rd(`ADCC_ADDR_CTRL, 32'h12);
    check(sample_hold_o, 1'b1);
    check(irq_o, 1'b0);
    conv(9'h033, 8'h33);
    rd(`ADCC_ADDR_ISTAT, 32'h3);
    xfer(1'b1, `ADCC_ADDR_ICLR, 32'h3);
    rd(`ADCC_ADDR_ISTAT, 32'h0);
    repeat (40) @(posedge clk_i);
    rd(`ADCC_ADDR_CTRL, 32'ha);
    check(sample_hold_o, 1'b0);
    global_irq_enable_i <= 1'b0;
    xfer(1'b1, `ADCC_ADDR_CTRL, 32'h3);
    repeat (CONV + 4) @(posedge clk_i);
    check(irq_o, 1'b0);
    rd(`ADCC_ADDR_CTRL, 32'ha);
    global_irq_enable_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    check(irq_o, 1'b1);
    xfer(1'b1, `ADCC_ADDR_IEN, 32'h3);
    rd(`ADCC_ADDR_IEN, 32'h3);
    xfer(1'b1, `ADCC_ADDR_CTRL, 32'h1);
    repeat (CONV + 4) @(posedge clk_i);
    check(irq_o, 1'b0);
    rd(`ADCC_ADDR_CTRL, 32'h8);
    xfer(1'b1, `ADCC_ADDR_CTRL, 32'h5);
    repeat (CONV + 4) @(posedge clk_i);
    rd(`ADCC_ADDR_CTRL, 32'h4);
    check(converter_powerdown_o, 1'b1);
    results();
  end
endmodule : adc_conversion_control_tb

// [dv/adcc_analog_model.sv]
// Behavioural analog front end that answers the converter's trial codes.
`timescale 1ns/100ps
module adcc_analog_model (
  input wire logic [8:0] level_i,
  input wire logic [7:0] dac_code_i,
  input wire logic [7:0] analog_select_i,
  input wire logic powerdown_i,
  output logic comparator_o,
  output logic at_upper_o,
  output logic at_lower_o
);
  // ****************************************
  // Comparator and reference flags
  // ****************************************
  logic live;
  // The input only means something when exactly one line is analog and power is on.
  assign live = !powerdown_i && $onehot(analog_select_i);
  // An unpowered comparator gives a level that tracks nothing useful.
  assign comparator_o = live ? ({1'b0, dac_code_i} <= level_i) : ~dac_code_i[0];
  assign at_upper_o = live && (level_i >= 9'h100);
  assign at_lower_o = live && (level_i == 9'h000);
endmodule : adcc_analog_model

// [verilog/adcc_cfg.svh]
// Register map, field positions, reset values and timing counts of the converter control.
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

`define ADCC_ADDR_CTRL 12'h000
`define ADCC_ADDR_RESULT 12'h004
`define ADCC_ADDR_ISTAT 12'h008
`define ADCC_ADDR_ICLR 12'h00c
`define ADCC_ADDR_IEN 12'h010

`define ADCC_CTRL_START 0
`define ADCC_CTRL_EAI 1
`define ADCC_CTRL_PDS 2
`define ADCC_CTRL_EOC 3
`define ADCC_CTRL_BUSY 4

`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_RESTART 1

`define ADCC_PDS_RST 1'b1
`define ADCC_EAI_RST 1'b0
`define ADCC_IEN_RST 2'h0

`define ADCC_SAMPLE_NUM 4
`define ADCC_BIT_NUM 3
`define ADCC_CONV_NUM ((`ADCC_SAMPLE_NUM) + 8 * (`ADCC_BIT_NUM))

`endif

// [verilog/adcc_ctrl.sv]
// Successive-approximation converter control with an APB register slave.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "adcc_cfg.svh"

module adcc_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] port_direction_reg_i,
  input wire logic [7:0] port_option_reg_i,
  input wire logic [7:0] port_data_reg_i,
  input wire logic global_irq_enable_i,
  input wire logic comparator_i,
  input wire logic at_upper_reference_i,
  input wire logic at_lower_reference_i,
  output logic [7:0] analog_select_o,
  output logic [7:0] dac_code_o,
  output logic sample_hold_o,
  output logic converter_powerdown_o,
  output logic irq_o
);
  import adcc_pkg::*;

  // ****************************************************************
  // Constants and state
  // ****************************************************************
  localparam int CONV_CYC = `ADCC_CONV_NUM;
  localparam logic [7:0] SAMPLE_LOAD = 8'(`ADCC_SAMPLE_NUM - 1);
  localparam logic [7:0] BIT_LOAD = 8'(`ADCC_BIT_NUM - 1);
  localparam adcc_regs_t RST = '{
    st: ADCC_IDLE,
    converter_powerdown_bit: `ADCC_PDS_RST,
    converter_irq_enable: `ADCC_EAI_RST,
    ien: `ADCC_IEN_RST,
    default: '0
  };

  adcc_regs_t q;
  adcc_regs_t d;
  logic [7:0] analog_mode;
  logic setup;
  logic wr_acc;
  logic start_take;
  logic start_go;
  logic addr_hit;
  logic [31:0] rd_val;
  logic [7:0] keep;
  logic [1:0] events;
  logic [1:0] clr;

  // ****************************************************************
  // Port line selection
  // ****************************************************************
  // A line is in analog mode when it is an input with option one and data zero.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_line
      assign analog_mode[gi] = ~port_direction_reg_i[gi] & port_option_reg_i[gi]
                               & ~port_data_reg_i[gi];
    end
  endgenerate

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign setup = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & q.pready & pwrite_i;
  assign start_take = wr_acc && (paddr_i == `ADCC_ADDR_CTRL) && pwdata_i[`ADCC_CTRL_START];
  // A start in the same write that sets power-down does not convert.
  assign start_go = start_take & ~pwdata_i[`ADCC_CTRL_PDS];
  assign clr = (wr_acc && (paddr_i == `ADCC_ADDR_ICLR)) ? pwdata_i[1:0] : 2'h0;
  assign keep = q.cmp_s2 ? q.sar : (q.sar & ~q.mask);

  always_comb begin
    addr_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr_i)
      `ADCC_ADDR_CTRL: begin
        rd_val[`ADCC_CTRL_EAI] = q.converter_irq_enable;
        rd_val[`ADCC_CTRL_PDS] = q.converter_powerdown_bit;
        rd_val[`ADCC_CTRL_EOC] = q.eoc;
        rd_val[`ADCC_CTRL_BUSY] = (q.st != ADCC_IDLE);
      end
      `ADCC_ADDR_RESULT: rd_val[7:0] = q.result;
      `ADCC_ADDR_ISTAT: rd_val[1:0] = q.ist;
      `ADCC_ADDR_ICLR: rd_val = 32'h0000_0000;
      `ADCC_ADDR_IEN: rd_val[1:0] = q.ien;
      default: addr_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    events = 2'h0;
    d.cmp_s1 = comparator_i;
    d.cmp_s2 = q.cmp_s1;
    d.up_s1 = at_upper_reference_i;
    d.up_s2 = q.up_s1;
    d.lo_s1 = at_lower_reference_i;
    d.lo_s2 = q.lo_s1;
    d.sel = analog_mode;
    d.pready = setup;
    d.pslverr = 1'b0;
    if (setup) begin
      d.pslverr = ~addr_hit;
      d.prdata = rd_val;
    end
    if (wr_acc) begin
      if (paddr_i == `ADCC_ADDR_CTRL) begin
        d.converter_irq_enable = pwdata_i[`ADCC_CTRL_EAI];
        d.converter_powerdown_bit = pwdata_i[`ADCC_CTRL_PDS];
      end
      if (paddr_i == `ADCC_ADDR_IEN) begin
        d.ien = pwdata_i[1:0];
      end
    end
    case (q.st)
      ADCC_IDLE: begin
        d.sample = 1'b0;
      end
      ADCC_SAMPLE: begin
        if (q.cnt == 8'h00) begin
          d.st = ADCC_CONVERT;
          d.cnt = BIT_LOAD;
          d.sample = 1'b0;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      ADCC_CONVERT: begin
        if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else if (q.mask[0]) begin
          d.sar = keep;
          if (q.up_s2) begin
            d.result = 8'hff;
          end else if (q.lo_s2) begin
            d.result = 8'h00;
          end else begin
            d.result = keep;
          end
          d.eoc = 1'b1;
          d.st = ADCC_IDLE;
          events[`ADCC_IRQ_DONE] = 1'b1;
        end else begin
          d.sar = keep | (q.mask >> 1);
          d.mask = q.mask >> 1;
          d.cnt = BIT_LOAD;
        end
      end
      default: d.st = ADCC_IDLE;
    endcase
    if (q.converter_powerdown_bit) begin
      d.st = ADCC_IDLE;
      d.sample = 1'b0;
    end
    if (start_take) begin
      d.eoc = 1'b0;
    end
    if (start_go) begin
      events[`ADCC_IRQ_RESTART] = (q.st != ADCC_IDLE);
      events[`ADCC_IRQ_DONE] = 1'b0;
      d.st = ADCC_SAMPLE;
      d.cnt = SAMPLE_LOAD;
      d.sar = 8'h80;
      d.mask = 8'h80;
      d.sample = 1'b1;
    end
    // A start write also drops a pending done bit; a new event wins over any clear.
    d.ist = (q.ist & ~clr & ~{1'b0, start_take}) | events;
    d.irq = global_irq_enable_i & q.converter_irq_enable & (q.eoc | (|(q.ist & q.ien)));
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign analog_select_o = q.sel;
  assign dac_code_o = q.sar;
  assign sample_hold_o = q.sample;
  assign converter_powerdown_o = q.converter_powerdown_bit;
  assign irq_o = q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Cycles since the last accepted start, saturating.
  logic [7:0] since_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      since_q <= 8'h00;
    end else if (ce_i) begin
      if (start_go) begin
        since_q <= 8'h00;
      end else if (since_q != 8'hff) begin
        since_q <= since_q + 8'h01;
      end
    end
  end

  // Cycles from the eighth cycle after a start until the end flag is visible.
  localparam int CONV_LATE = CONV_CYC - 7;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i || !ce_i);

  sequence s_go;
    start_go;
  endsequence

  sequence s_done;
    $rose(q.eoc);
  endsequence

  sequence s_read_ctrl;
    setup && (paddr_i == `ADCC_ADDR_CTRL);
  endsequence

  sequence s_read_result;
    setup && (paddr_i == `ADCC_ADDR_RESULT);
  endsequence

  property p_sat_high;
    s_done and $past(q.up_s2) |-> (q.result == 8'hff);
  endproperty
  a_sat_high: assert property (p_sat_high) else $error("full scale not ff");

  property p_sat_low;
    s_done and (!$past(q.up_s2) && $past(q.lo_s2)) |-> (q.result == 8'h00);
  endproperty
  a_sat_low: assert property (p_sat_low) else $error("zero scale not 00");

  property p_result_read;
    s_read_result |=> (prdata_o == {24'h000000, $past(q.result)}) && pready_o;
  endproperty
  a_result_read: assert property (p_result_read) else $error("result read wrong");

  property p_select;
    !$past(sys_rst_i) && $past(ce_i) |-> (analog_select_o == $past(analog_mode));
  endproperty
  a_select: assert property (p_select) else $error("select not following port");

  property p_powerdown;
    q.converter_powerdown_bit && !start_go |=> (q.st == ADCC_IDLE) && !sample_hold_o;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("runs while off");

  property p_start_clears;
    start_take |=> !q.eoc;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start kept end flag");

  property p_sample_start;
    s_go |=> sample_hold_o && (dac_code_o == 8'h80);
  endproperty
  a_sample_start: assert property (p_sample_start) else $error("start did not sample");

  property p_end_flag;
    s_done |-> ($past(q.st) == ADCC_CONVERT) && (q.st == ADCC_IDLE);
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag without finish");

  property p_result_held;
    q.eoc && !start_go |=> $stable(q.result);
  endproperty
  a_result_held: assert property (p_result_held) else $error("result moved while valid");

  property p_irq_on;
    global_irq_enable_i && q.converter_irq_enable && q.eoc |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("request missing");

  property p_irq_off;
    !q.converter_irq_enable |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while disabled");

  property p_one_shot;
    (q.st == ADCC_IDLE) && !start_go |=> (q.st == ADCC_IDLE);
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("conversion without start");

  property p_restart;
    s_go and (q.st != ADCC_IDLE) |=> (q.st == ADCC_SAMPLE) && (q.cnt == SAMPLE_LOAD)
      && q.ist[`ADCC_IRQ_RESTART];
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  property p_start_reads_zero;
    s_read_ctrl |=> (prdata_o[`ADCC_CTRL_START] == 1'b0);
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) else $error("start bit read one");

  property p_global;
    !global_irq_enable_i |=> !irq_o;
  endproperty
  a_global: assert property (p_global) else $error("request passed global mask");

  property p_conv_time;
    s_done |-> (since_q == 8'(CONV_CYC));
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

  property p_conv_bound;
    s_go ##1 (!start_go && !q.converter_powerdown_bit)[*8] |-> ##[1:CONV_LATE] (q.eoc || start_go || q.converter_powerdown_bit);
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("end flag late");

endmodule : adcc_ctrl

// [verilog/adcc_pkg.sv]
// Types shared by the converter control design.
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_SAMPLE,
    ADCC_CONVERT
  } adcc_state_t;

  typedef struct packed {
    adcc_state_t st;
    logic [7:0] cnt;
    logic [7:0] sar;
    logic [7:0] mask;
    logic [7:0] result;
    logic sample;
    logic eoc;
    logic converter_irq_enable;
    logic converter_powerdown_bit;
    logic [1:0] ist;
    logic [1:0] ien;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmp_s1;
    logic cmp_s2;
    logic up_s1;
    logic up_s2;
    logic lo_s1;
    logic lo_s2;
    logic [7:0] sel;
  } adcc_regs_t;

endpackage : adcc_pkg
